// ### verilog/timer_channel.sv
// Purpose: One timer channel with measurement and PWM modes
// Assumes: AXI4-Lite register access, single clock mclk
// Notes: Timer pin is sampled through a synchroniser
// Function
// - Mode field 4..7 selects width/period/capture/PWM
// - Synchronise timer pin; count may vary one
// - Width: start edge per polarity loads counter
// - Width: opposite edge flags, captures count, stops if reload set
// - Width: reload on next start, else increment
// - Period: same-polarity edges, polarity picks falling
// - Period: first edge loads, next captures and flags
// - Period: reload repeats, else count to overflow
// - Capture: count from enable, halt at edge
// - Capture: polarity set ends on falling edge
// - PWM compare match toggles, flags, captures, continues
// - PWM overflow toggles pin, sets overflow flag
// - PWM reload loads counter after overflow
// - PWM pin starts at polarity, inverts per toggle
// - PWM period with reload: all-ones minus load plus one
// - Enable clears counter; clearing enable stops channel

`timescale 1ns/1ns

module timer_channel
  import timer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_pin_in,
  output logic timer_pin_out,
  output logic timer_pin_oe,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Word match of a byte address against a register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  // Any mapped register
  function automatic logic mapped(input logic [7:0] a);
    return hit(a, OFF_CTRL) | hit(a, OFF_STATUS) | hit(a, OFF_MASK) | hit(a, OFF_LOAD) |
      hit(a, OFF_CMP) | hit(a, OFF_CAPT) | hit(a, OFF_COUNT);
  endfunction

  // Byte-lane merge of write data into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0] awaddr_r;
  logic [31:0] wdata_r, rd_word, wmerged;
  logic [3:0] wstrb_r, mode;
  logic [CTRL_W-1:0] ctrl_r;
  logic [23:0] load_r, cmp_r, capt_r, cnt_r, cnt_nxt, cnt_inc;
  chan_state_t st_r, st_nxt;
  logic [1:0] status, mask;
  logic do_write, en_q_r, pin_nxt, cmp_evt, ovf_evt, capt_we;
  logic pol, reload, en, start_edge, end_edge, wrap;

  pin_edge_if edges ();

  assign mode = ctrl_r[CTRL_MODE_MSB:CTRL_MODE_LSB];
  assign pol = ctrl_r[CTRL_POL_BIT];
  assign reload = ctrl_r[CTRL_RELOAD_BIT];
  assign en = ctrl_r[CTRL_EN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and event flags

  // Pin edges come only through the synchroniser
  pin_edge u_pin_edge (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin_in(timer_pin_in),
    .edges(edges.src)
  );

  // Starting edge is falling when polarity set, else rising
  assign start_edge = pol ? edges.fall : edges.rise;
  assign end_edge = pol ? edges.rise : edges.fall;

  irq_unit u_irq (
    .mclk(mclk),
    .rst_n(rst_n),
    .evt({ovf_evt, cmp_evt}),
    .clr_we(do_write & hit(awaddr_r, OFF_STATUS)),
    .clr_data(wdata_r[1:0] & {2{wstrb_r[0]}}), // A lane not written clears nothing
    .mask_we(do_write & hit(awaddr_r, OFF_MASK)),
    .mask_data(wmerged[1:0]),
    .status(status),
    .mask(mask),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  // Write data merged with the addressed register by byte lanes
  always_comb wmerged = merge(rd_word_at(awaddr_r), wdata_r, wstrb_r);
  assign do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

  // Address and data taken in either order, response after both
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awaddr_r <= 8'h00;
      wdata_r <= WORD_ZERO;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  // Control (7 bits), load and compare values on 24-bit paths
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
      load_r <= CNT_ZERO;
      cmp_r <= CNT_ZERO;
    end else if (do_write) begin
      if (hit(awaddr_r, OFF_CTRL)) begin
        ctrl_r <= wmerged[CTRL_W-1:0];
      end
      if (hit(awaddr_r, OFF_LOAD)) begin
        load_r <= wmerged[23:0];
      end
      if (hit(awaddr_r, OFF_CMP)) begin
        cmp_r <= wmerged[23:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  // Register read mux
  function automatic logic [31:0] rd_word_at(input logic [7:0] a);
    logic [31:0] v;
    v = WORD_ZERO;
    if (hit(a, OFF_CTRL)) begin
      v[CTRL_W-1:0] = ctrl_r;
    end else if (hit(a, OFF_STATUS)) begin
      v[1:0] = status;
    end else if (hit(a, OFF_MASK)) begin
      v[1:0] = mask;
    end else if (hit(a, OFF_LOAD)) begin
      v[23:0] = load_r;
    end else if (hit(a, OFF_CMP)) begin
      v[23:0] = cmp_r;
    end else if (hit(a, OFF_CAPT)) begin
      v[23:0] = capt_r;
    end else if (hit(a, OFF_COUNT)) begin
      v[23:0] = cnt_r;
    end
    return v;
  endfunction

  // Process form, so every register the mux reads keeps the word live
  always_comb rd_word = rd_word_at(s_axi_araddr);

  // One read at a time, answered on the edge after the address
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= WORD_ZERO;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counting engine

  assign cnt_inc = cnt_r + CNT_ONE;
  assign wrap = (cnt_r == CNT_ALL_ONES);

  // Next counter, state, pin level and events
  always_comb begin
    cnt_nxt = cnt_r;
    st_nxt = st_r;
    pin_nxt = timer_pin_out;
    cmp_evt = 1'b0;
    ovf_evt = 1'b0;
    capt_we = 1'b0;
    if (!en) begin
      st_nxt = ST_OFF;
    end else if (!en_q_r) begin
      cnt_nxt = CNT_ZERO;
      st_nxt = (mode == MODE_CAPTURE) ? ST_RUN : ST_ARM;
      pin_nxt = pol;
    end else begin
      case (st_r)
        ST_ARM: begin
          if (mode == MODE_PWM) begin
            cnt_nxt = load_r;
            st_nxt = ST_RUN;
          end else if ((mode == MODE_WIDTH || mode == MODE_PERIOD) && start_edge) begin
            cnt_nxt = load_r;
            st_nxt = ST_RUN;
          end
        end
        ST_RUN: begin
          cnt_nxt = cnt_inc;
          ovf_evt = wrap;
          case (mode)
            MODE_WIDTH: begin
              if (end_edge) begin
                capt_we = 1'b1;
                cmp_evt = 1'b1;
                if (reload) begin
                  cnt_nxt = cnt_r;
                  ovf_evt = 1'b0;
                  st_nxt = ST_ARM;
                end
              end
            end
            MODE_PERIOD: begin
              if (start_edge) begin
                capt_we = 1'b1;
                cmp_evt = 1'b1;
                if (reload) begin
                  cnt_nxt = load_r;
                end
              end
            end
            MODE_CAPTURE: begin
              if (start_edge) begin
                capt_we = 1'b1;
                cmp_evt = 1'b1;
                cnt_nxt = cnt_r;
                ovf_evt = 1'b0;
                st_nxt = ST_HALT;
              end
            end
            MODE_PWM: begin
              if (cnt_r == cmp_r) begin
                pin_nxt = ~pin_nxt;
                cmp_evt = 1'b1;
                capt_we = 1'b1;
              end
              if (wrap) begin
                pin_nxt = ~pin_nxt;
                if (reload) begin
                  cnt_nxt = load_r;
                end
              end
            end
            default: begin
              cnt_nxt = cnt_r;
              ovf_evt = 1'b0;
            end
          endcase
        end
        ST_HALT: begin
          cnt_nxt = cnt_r;
        end
        default: begin
          st_nxt = ST_OFF;
        end
      endcase
    end
  end

  // Engine state and counter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_OFF;
      cnt_r <= CNT_ZERO;
      en_q_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      en_q_r <= en;
    end
  end

  // Captured count register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      capt_r <= CNT_ZERO;
    end else if (capt_we) begin
      capt_r <= cnt_r;
    end
  end

  // Pin drive only while enabled in PWM mode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_pin_out <= 1'b0;
      timer_pin_oe <= 1'b0;
    end else begin
      timer_pin_out <= pin_nxt;
      timer_pin_oe <= en & (mode == MODE_PWM);
    end
  end

endmodule

// ### include/timer_pkg.sv
// Purpose: Constants and types shared by the timer channel and its helpers
// Assumes: 32-bit register bus, 24-bit counting path
// Notes: Byte offsets are word aligned

package timer_pkg;

  // Counting path
  localparam int CNT_W = 24;
  localparam logic [23:0] CNT_ALL_ONES = 24'hffffff;
  localparam logic [23:0] CNT_ZERO = 24'h000000;
  localparam logic [23:0] CNT_ONE = 24'h000001;

  // Register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_LOAD = 8'h0c;
  localparam logic [7:0] OFF_CMP = 8'h10;
  localparam logic [7:0] OFF_CAPT = 8'h14;
  localparam logic [7:0] OFF_COUNT = 8'h18;

  // Control register fields
  localparam int CTRL_W = 7;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_MSB = 3;
  localparam int CTRL_POL_BIT = 4;
  localparam int CTRL_RELOAD_BIT = 5;
  localparam int CTRL_EN_BIT = 6;
  localparam logic [6:0] CTRL_RST = 7'h00;

  // Status and mask fields
  localparam int FLAG_W = 2;
  localparam int FLAG_CMP_BIT = 0;
  localparam int FLAG_OVF_BIT = 1;
  localparam logic [1:0] FLAG_RST = 2'h0;

  // Mode codes
  localparam logic [3:0] MODE_WIDTH = 4'h4;
  localparam logic [3:0] MODE_PERIOD = 4'h5;
  localparam logic [3:0] MODE_CAPTURE = 4'h6;
  localparam logic [3:0] MODE_PWM = 4'h7;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  typedef enum logic [1:0] {ST_OFF, ST_ARM, ST_RUN, ST_HALT} chan_state_t;

endpackage

// ### include/pin_edge_if.sv
// Purpose: Edge pulses of the synchronised timer pin
// Assumes: One clock domain
// Notes: Pulses last one clock

`timescale 1ns/1ns

interface pin_edge_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface

// ### verilog/pin_edge.sv
// Purpose: Synchronise the timer pin and report its edges
// Assumes: Pin is asynchronous to mclk
// Notes: Edges appear two clocks after the pin moves at most

`timescale 1ns/1ns

module pin_edge
  import timer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pin_in,
  pin_edge_if.src edges
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // Two-stage synchroniser, then one stage of history
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Edge pulses from synchronised stages only
  assign edges.rise = sync_r & ~prev_r;
  assign edges.fall = ~sync_r & prev_r;

endmodule

// ### verilog/irq_unit.sv
// Purpose: Sticky event flags, mask and level interrupt
// Assumes: Flags cleared by writing ones
// Notes: A set in the clearing cycle wins

`timescale 1ns/1ns

module irq_unit
  import timer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] evt,
  input wire logic clr_we,
  input wire logic [1:0] clr_data,
  input wire logic mask_we,
  input wire logic [1:0] mask_data,
  output logic [1:0] status,
  output logic [1:0] mask,
  output logic irq
);

  logic [1:0] status_nxt;

  // Clear first, then set, so a new event survives
  always_comb begin
    status_nxt = status;
    if (clr_we) begin
      status_nxt = status_nxt & ~clr_data;
    end
    status_nxt = status_nxt | evt;
  end

  // Flag, mask and interrupt registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status <= FLAG_RST;
      mask <= FLAG_RST;
      irq <= 1'b0;
    end else begin
      status <= status_nxt;
      if (mask_we) begin
        mask <= mask_data;
      end
      irq <= |(status & mask);
    end
  end

endmodule

// ### tb/timer_props.sv
// Purpose: Port-level assertions for the timer channel
// Assumes: Address and data of a write are taken together
// Notes: Shadows of ctrl, load and compare follow bus writes
`timescale 1ns/1ns
module timer_props
  import timer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_pin_out,
  input wire logic timer_pin_oe
);
  logic [6:0] ctrl_r;
  logic [23:0] load_r, cmp_r, gap_r;
  logic pin_q_r, oe_q_r, seen_r, wr_go, tgl;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Whole write taken, and a toggle of the driven pin
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign tgl = timer_pin_oe && oe_q_r && (timer_pin_out != pin_q_r);
  // Shadow of the programmed setup
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
      load_r <= CNT_ZERO;
      cmp_r <= CNT_ZERO;
    end else if (wr_go) begin
      if (s_axi_awaddr == OFF_CTRL) ctrl_r <= s_axi_wdata[6:0];
      if (s_axi_awaddr == OFF_LOAD) load_r <= s_axi_wdata[23:0];
      if (s_axi_awaddr == OFF_CMP) cmp_r <= s_axi_wdata[23:0];
    end
  end
  // Cycles since the last toggle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q_r <= 1'b0;
      oe_q_r <= 1'b0;
      seen_r <= 1'b0;
      gap_r <= CNT_ZERO;
    end else begin
      pin_q_r <= timer_pin_out;
      oe_q_r <= timer_pin_oe;
      seen_r <= timer_pin_oe && (seen_r || tgl);
      gap_r <= tgl ? CNT_ONE : gap_r + CNT_ONE;
    end
  end
  ////////////////////////////////////////
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp not held");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata not held");
  a_write_answer: assert property (wr_go |-> ##[1:2] s_axi_bvalid)
    else $error("no write answer");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  a_write_block: assert property (wr_go |=> !s_axi_awready && !s_axi_wready)
    else $error("readies stayed high");
  a_oe_by_write: assert property ($changed(timer_pin_oe) |->
    s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("drive changed without write");
  a_pin_start: assert property ($rose(timer_pin_oe) |-> timer_pin_out == ctrl_r[CTRL_POL_BIT])
    else $error("pin start level wrong");
  a_drive_pwm_only: assert property ($rose(timer_pin_oe) |-> ctrl_r[3:0] == MODE_PWM && ctrl_r[CTRL_EN_BIT])
    else $error("pin driven outside pwm");
  a_pwm_gap: assert property (tgl && seen_r && ctrl_r[3:0] == MODE_PWM |-> gap_r == CNT_ALL_ONES - cmp_r ||
    gap_r == (ctrl_r[CTRL_RELOAD_BIT] ? cmp_r - load_r + CNT_ONE : cmp_r + CNT_ONE)) else $error("pwm gap wrong");
  c_write: cover property (wr_go);
  c_drive: cover property ($rose(timer_pin_oe));
  c_toggle: cover property (tgl && seen_r);
endmodule

// ### tb/pin_source.sv
// Purpose: Signal source on the far side of the timer pin
// Assumes: Source changes just after a clock edge
// Notes: Square wave of two half periods while the generator runs
`timescale 1ns/1ns
module pin_source (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic gen_on,
  input wire logic lvl,
  input wire logic [7:0] half,
  input wire logic dut_out,
  input wire logic dut_oe,
  output logic pin
);
  logic src_r;
  logic [7:0] cnt_r;
  // Follow the requested level, or toggle each half period
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      src_r <= 1'b0;
      cnt_r <= 8'h00;
    end else if (!gen_on) begin
      src_r <= lvl;
      cnt_r <= 8'h00;
    end else if (cnt_r == half - 8'h01) begin
      src_r <= ~src_r;
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  // The channel owns the wire while it drives
  assign pin = dut_oe ? dut_out : src_r;
endmodule

// ### tb/testbench.sv
// Purpose: Self-checking bench for the timer channel
// Assumes: Pin source drives the pin unless the channel does
// Notes: Measured counts allow two clocks of synchroniser slack
`timescale 1ns/1ns
bind timer_channel timer_props chk_u (.*);
module testbench import timer_pkg::*;;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} row_t;
  logic mclk, rst_n, lvl, gen_on, irq, timer_pin_in, timer_pin_out, timer_pin_oe;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat, tmp;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  int n_mismatch = 0, checks = 0, cyc = 0;
  row_t rows[6];
  timer_channel dut_u (.*);
  pin_source src_u (.mclk, .rst_n, .gen_on, .lvl, .half(8'h19), .dut_out(timer_pin_out),
    .dut_oe(timer_pin_oe), .pin(timer_pin_in));
  ////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic rng(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi, input string m);
    checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h", $time, m, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    rst_n = 1'b0;
    {lvl, gen_on, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    rows = '{'{OFF_LOAD, 32'habcdef12, 32'hcdef12, RESP_OKAY}, '{OFF_CMP, 32'hffffff00, 32'hffff00, RESP_OKAY},
      '{OFF_MASK, 32'hffffffff, 32'h3, RESP_OKAY}, '{OFF_STATUS, 32'hffffffff, 32'h0, RESP_OKAY},
      '{OFF_CTRL, 32'hffffff83, 32'h3, RESP_OKAY}, '{8'h40, 32'h1, 32'h0, RESP_SLVERR}};
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    // Register table, unmapped place last
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk(rsp, rows[i].r, "bresp");
      rd(rows[i].a);
      chk(rdat, rows[i].e, "rdata");
      chk(rsp, rows[i].r, "rresp");
    end
    // Reset in mid-run
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(OFF_LOAD);
    chk(rdat, 32'h0, "load after reset");
    // Capture ends on a falling edge only; a rise comes first
    wr(OFF_MASK, 32'h1);
    wr(OFF_CTRL, 32'h56);
    repeat (10) @(posedge mclk);
    lvl <= 1'b1;
    repeat (20) @(posedge mclk);
    lvl <= 1'b0;
    repeat (8) @(posedge mclk);
    rd(OFF_CAPT);
    rng(rdat, 32'h1e, 32'h26, "capture");
    rd(OFF_COUNT);
    tmp = rdat;
    rd(OFF_COUNT);
    chk(rdat, tmp, "halted");
    rd(OFF_STATUS);
    chk(rdat, 32'h1, "compare flag");
    chk(irq, 1'b1, "compare irq");
    wr(OFF_STATUS, 32'h1);
    rd(OFF_STATUS);
    chk(rdat, 32'h0, "flag cleared");
    chk(irq, 1'b0, "irq cleared");
    wr(OFF_CTRL, 32'h0);
    // Width with reload: two pulses, counter held between
    wr(OFF_LOAD, 32'h100);
    wr(OFF_CTRL, 32'h64);
    for (int i = 0; i < 2; i++) begin
      repeat (5) @(posedge mclk);
      lvl <= 1'b1;
      repeat (40 - 20 * i) @(posedge mclk);
      lvl <= 1'b0;
      repeat (8) @(posedge mclk);
      tmp = 32'h128 - 32'h14 * i;
      rd(OFF_CAPT);
      rng(rdat, tmp - 32'h2, tmp + 32'h2, "width");
      rd(OFF_COUNT);
      tmp = rdat;
      rd(OFF_COUNT);
      chk(rdat, tmp, "width stop");
    end
    wr(OFF_CTRL, 32'h0);
    // Period on falling edges, 50 clocks
    wr(OFF_LOAD, 32'h10);
    wr(OFF_CTRL, 32'h75);
    gen_on <= 1'b1;
    repeat (200) @(posedge mclk);
    rd(OFF_CAPT);
    rng(rdat, 32'h40, 32'h44, "period");
    gen_on <= 1'b0;
    wr(OFF_CTRL, 32'h0);
    wr(OFF_CTRL, 32'h40);
    repeat (3) @(posedge mclk);
    chk(timer_pin_oe, 1'b0, "no drive in mode 0");
    // PWM with reload, both polarities; compare above load
    wr(OFF_LOAD, 32'hffffc0);
    wr(OFF_CMP, 32'hffffd0);
    wr(OFF_MASK, 32'h2);
    for (int p = 0; p < 2; p++) begin
      wr(OFF_CTRL, 32'h0);
      wr(OFF_STATUS, 32'h3);
      wr(OFF_CTRL, 32'h67 | (32'h10 * p));
      repeat (2) @(posedge mclk);
      chk(timer_pin_oe, 1'b1, "drive");
      chk(timer_pin_out, p[0], "start level");
      repeat (150) @(posedge mclk);
      rd(OFF_CAPT);
      chk(rdat, 32'hffffd0, "compare capture");
      rd(OFF_STATUS);
      chk(rdat, 32'h3, "pwm flags");
      chk(irq, 1'b1, "overflow irq");
    end
    wr(OFF_CTRL, 32'h0);
    summarize();
  end
endmodule
